// file: core/sadc_ctrl.sv
// Behaviour
// - format bit 0 gives plain unsigned binary result codes.
// - format bit 1 gives two's complement, inverting only the top bit.
// - format change applies to the next conversion, not bits now shifting.
// - conversion-done is high whenever the converter sits in reset state.
// - conversion-done stays high through sampling, falls after last edge.
// - result latch raises conversion-done and returns to reset state.
// - with select low, first result bit shows at conversion-done rise.
// - after deselect, first result bit shows when select falls.
// - each later falling shift edge advances to the next result bit.
// - 8-bit mode drops four low bits; 12-bit sends all, msb-justified.
// - 16-bit mode pads four zeros below the lsb.
// - during conversion the serial output is forced to zero.
// - deselect floats output at once, ignores clock after debounce.
// - select held low for the debounce time resets bit counters, sampling and conversion.
// - abort keeps previous result to send in the next transfer.
// - address 1110 enters power-down at the fourth falling edge.
// - power-down skips conversion, keeps result, serial logic runs.
// - start powered down until a non power-down address arrives.
// - sampling runs from fourth falling edge to last falling edge.
// - addresses 0000 to 1010 pick external inputs 0 to 10.
// - 1011, 1100, 1101 pick midpoint, low and high test voltages.
// - first four command bits give the next conversion's channel.
// - command bits 3:2 pick 12, 16 or 8 bits for this transfer.
// - command bit 1 picks shift order for the next transfer.
`timescale 1ns/1ps
`include "sadc_cfg.svh"

module sadc_ctrl (
  input  wire logic              I_CLK_SYS,      // system clock, 40 MHz
  input  wire logic              I_RST_N,        // async reset, active low
  input  wire logic              I_IO_CLK,       // host shift clock pin
  input  wire logic              I_CS_N,         // device select pin
  input  wire logic              I_DIN,          // serial command pin
  input  wire sadc_pkg::result_t I_CONV_RAW,     // raw code of external input
  output logic                   O_DOUT,         // serial result
  output logic                   O_DOUT_OE_N,    // low while driving DOUT
  output logic                   O_EOC,          // conversion done
  output logic                   O_SAMPLE,       // sampling switch closed
  output logic [3:0]             O_CHAN,         // selected channel address
  output logic                   O_PWRDN,        // power-down state
  input  wire logic              PSEL,           // apb select
  input  wire logic              PENABLE,        // apb enable
  input  wire logic              PWRITE,         // apb direction
  input  wire logic [7:0]        PADDR,          // apb byte address
  input  wire logic [31:0]       PWDATA,         // apb write data
  output logic [31:0]            PRDATA,         // apb read data
  output logic                   PREADY,         // apb ready
  output logic                   PSLVERR         // apb error
);
  import sadc_pkg::*;

  // ==========================================================
  // helpers
  // ==========================================================
  // serial bit k of a frame of n bits built from coded result r
  function automatic logic pick_bit(input result_t r, input bitcnt_t n,
                                    input logic lsb_first_bit, input bitcnt_t k);
    bitcnt_t i;
    i = 5'd0;
    pick_bit = 1'b0;
    if (k < n)
    begin
      if (!lsb_first_bit)
      begin
        i = 5'd11 - k;
        pick_bit = (k < 5'd12) ? r[i[3:0]] : 1'b0;
      end
      else if (n == `SADC_LEN_16)
      begin
        i = k - 5'd4;
        pick_bit = (k < 5'd4) ? 1'b0 : r[i[3:0]];
      end
      else if (n == `SADC_LEN_8)
      begin
        i = k + 5'd4;
        pick_bit = r[i[3:0]];
      end
      else
        pick_bit = r[k[3:0]];
    end
  endfunction : pick_bit

  // frame length from the two length select bits
  function automatic bitcnt_t len_of(input logic hi, input logic lo);
    if (hi && lo)
      len_of = `SADC_LEN_16;
    else if (lo)
      len_of = `SADC_LEN_8;
    else
      len_of = `SADC_LEN_12;
  endfunction : len_of

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic        clk_s1_q, clk_s2_q, clk_s3_q;
  logic        cs_s1_q, cs_s2_q;
  logic        din_s1_q, din_s2_q;

  // two flops per pin before any logic looks at it
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end
    else
    begin
      clk_s1_q <= I_IO_CLK;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      cs_s1_q  <= I_CS_N;
      cs_s2_q  <= cs_s1_q;
      din_s1_q <= I_DIN;
      din_s2_q <= din_s1_q;
    end
  end

  // ==========================================================
  // select debounce
  // ==========================================================
  logic        cs_deb_q;
  logic [7:0]  dbnc_cnt_q;
  logic [7:0]  dbnc_cyc_q;
  logic        cs_done;
  logic        sel_reset;

  // the debounced level only moves once the pin has held steady
  assign cs_done   = (cs_s2_q != cs_deb_q) && (dbnc_cnt_q >= dbnc_cyc_q);
  assign sel_reset = cs_done && !cs_s2_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cs_deb_q   <= 1'b1;
      dbnc_cnt_q <= 8'h00;
    end
    else if (cs_s2_q == cs_deb_q || cs_done)
    begin
      cs_deb_q   <= cs_s2_q;
      dbnc_cnt_q <= 8'h00;
    end
    else
      dbnc_cnt_q <= dbnc_cnt_q + 8'h01;
  end

  // ==========================================================
  // shift clock edges and transfer sequencing
  // ==========================================================
  conv_state_e state_q;
  logic [7:0]  cmd_q;
  bitcnt_t     rise_cnt_q, fall_cnt_q, len_q;
  logic        lsb_first_bit_q, fmt_q, pwrdn_q, samp_q;
  logic [3:0]  chan_q;
  logic [15:0] conv_cnt_q, conv_cyc_q;
  result_t     raw_q, result_q;
  logic        io_rise, io_fall, live, last_fall, conv_end;
  logic        addr_fall;
  result_t     raw_sel;
  bitcnt_t     len_new;

  // clock ignored while deselected after debounce
  assign live      = !cs_deb_q;
  assign io_rise   = live && clk_s2_q && !clk_s3_q;
  assign io_fall   = live && !clk_s2_q && clk_s3_q;
  assign len_new   = len_of(cmd_q[0], din_s2_q);
  assign addr_fall = io_fall && (fall_cnt_q == 5'd3);
  assign last_fall = io_fall && (fall_cnt_q + 5'd1 == len_q)
                     && (state_q == ST_XFER);
  assign conv_end  = (state_q == ST_CONV) && (conv_cnt_q == 16'h0000);

  // test addresses convert fixed codes like any other input
  assign raw_sel = (chan_q == `SADC_ADDR_TMID)  ? `SADC_CODE_MID  :
                   (chan_q == `SADC_ADDR_TLOW)  ? `SADC_CODE_LOW  :
                   (chan_q == `SADC_ADDR_THIGH) ? `SADC_CODE_HIGH :
                   I_CONV_RAW;

  // command capture, bit counters and frame length
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cmd_q      <= 8'h00;
      rise_cnt_q <= 5'd0;
      fall_cnt_q <= 5'd0;
      len_q      <= `SADC_LEN_12;
    end
    else if (sel_reset || last_fall || conv_end)
    begin
      rise_cnt_q <= 5'd0;
      fall_cnt_q <= 5'd0;
    end
    else
    begin
      if (io_rise && rise_cnt_q < 5'd8)
      begin
        cmd_q      <= {cmd_q[6:0], din_s2_q};
        rise_cnt_q <= rise_cnt_q + 5'd1;
        if (rise_cnt_q == 5'd5)
          len_q <= len_new;
      end
      if (io_fall && state_q == ST_XFER)
        fall_cnt_q <= fall_cnt_q + 5'd1;
    end
  end

  // channel, power-down, sampling and conversion state
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_q    <= ST_XFER;
      pwrdn_q    <= 1'b1;
      samp_q     <= 1'b0;
      chan_q     <= 4'h0;
      fmt_q      <= 1'b0;
      lsb_first_bit_q     <= 1'b0;
      raw_q      <= 12'h000;
      result_q   <= 12'h000;
      conv_cnt_q <= 16'h0000;
    end
    else if (sel_reset)
    begin
      state_q <= ST_XFER;
      samp_q  <= 1'b0;
    end
    else
    begin
      if (addr_fall)
      begin
        chan_q  <= cmd_q[3:0];
        pwrdn_q <= (cmd_q[3:0] == `SADC_ADDR_PDN);
        samp_q  <= (cmd_q[3:0] != `SADC_ADDR_PDN);
      end
      if (last_fall)
      begin
        samp_q <= 1'b0;
        raw_q  <= raw_sel;
        fmt_q  <= cmd_q[`SADC_FMT_BIT];
        lsb_first_bit_q <= cmd_q[`SADC_ORD_BIT];
        if (!pwrdn_q)
        begin
          state_q    <= ST_CONV;
          conv_cnt_q <= conv_cyc_q;
        end
      end
      if (state_q == ST_CONV && conv_cnt_q != 16'h0000)
        conv_cnt_q <= conv_cnt_q - 16'h0001;
      if (conv_end)
      begin
        // signed code only flips the top bit
        result_q <= raw_q ^ {fmt_q, 11'h000};
        state_q  <= ST_XFER;
      end
    end
  end

  // ==========================================================
  // pin outputs
  // ==========================================================
  // recomputed every cycle, so the first bit follows a fresh
  // result or a reload on select without extra sequencing
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_DOUT      <= 1'b0;
      O_DOUT_OE_N <= 1'b1;
      O_EOC       <= 1'b1;
      O_SAMPLE    <= 1'b0;
      O_CHAN      <= 4'h0;
      O_PWRDN     <= 1'b1;
    end
    else
    begin
      O_DOUT      <= (state_q == ST_CONV) ? 1'b0 :
                     pick_bit(result_q, len_q, lsb_first_bit_q,
                              fall_cnt_q);
      O_DOUT_OE_N <= cs_s2_q;
      O_EOC       <= (state_q != ST_CONV);
      O_SAMPLE    <= samp_q;
      O_CHAN      <= chan_q;
      O_PWRDN     <= pwrdn_q;
    end
  end

  // ==========================================================
  // apb slave
  // ==========================================================
  logic        acc, wr_hit;
  logic [31:0] rd_word;
  logic        rd_err;

  // one wait state keeps read data and ready straight from flops
  assign acc    = PSEL && PENABLE && !PREADY;
  assign wr_hit = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (PADDR)
      `SADC_OFS_CONV_CYC: rd_word = {16'h0000, conv_cyc_q};
      `SADC_OFS_DBNC_CYC: rd_word = {24'h00_0000, dbnc_cyc_q};
      `SADC_OFS_STATUS:   rd_word = {24'h00_0000, chan_q, 1'b0,
                                     samp_q, state_q == ST_XFER, pwrdn_q};
      `SADC_OFS_RESULT:   rd_word = {20'h0_0000, result_q};
      default:            rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      PREADY     <= 1'b0;
      PRDATA     <= 32'h0000_0000;
      PSLVERR    <= 1'b0;
      conv_cyc_q <= 16'(`SADC_CONV_CYC_RST);
      dbnc_cyc_q <= 8'(`SADC_DBNC_CYC_RST);
    end
    else
    begin
      PREADY  <= acc;
      PSLVERR <= acc && rd_err;
      PRDATA  <= (acc && !PWRITE && !rd_err) ? rd_word : 32'h0000_0000;
      if (wr_hit && PADDR == `SADC_OFS_CONV_CYC)
        conv_cyc_q <= PWDATA[15:0];
      if (wr_hit && PADDR == `SADC_OFS_DBNC_CYC)
        dbnc_cyc_q <= PWDATA[7:0];
    end
  end

endmodule : sadc_ctrl

// file: core/sadc_cfg.svh
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// register byte offsets
`define SADC_OFS_CONV_CYC  8'h00
`define SADC_OFS_DBNC_CYC  8'h04
`define SADC_OFS_STATUS    8'h08
`define SADC_OFS_RESULT    8'h0C

// timing, printed unit and derived cycles at the system clock
`define SADC_CLK_PERIOD_NS 25
`define SADC_T_CONV_NS     10000
`define SADC_T_DBNC_NS     100
`define SADC_CONV_CYC_RST  ((`SADC_T_CONV_NS) / (`SADC_CLK_PERIOD_NS))
`define SADC_DBNC_CYC_RST \
  (((`SADC_T_DBNC_NS) + (`SADC_CLK_PERIOD_NS) - 1) / (`SADC_CLK_PERIOD_NS))

// command word field positions
`define SADC_FMT_BIT       0
`define SADC_ORD_BIT       1
`define SADC_ADDR_PDN      4'hE
`define SADC_ADDR_TMID     4'hB
`define SADC_ADDR_TLOW     4'hC
`define SADC_ADDR_THIGH    4'hD

// test voltage codes and frame lengths
`define SADC_CODE_MID      12'h800
`define SADC_CODE_LOW      12'h000
`define SADC_CODE_HIGH     12'hFFF
`define SADC_LEN_8         5'd8
`define SADC_LEN_12        5'd12
`define SADC_LEN_16        5'd16

`endif

// file: core/sadc_pkg.sv
package sadc_pkg;
  typedef enum logic [1:0] {
    ST_XFER = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;
  typedef logic [11:0] result_t;
  typedef logic [4:0]  bitcnt_t;
endpackage : sadc_pkg

// file: tb/sadc_ctrl_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checker for the converter control block
module sadc_ctrl_chk (
  input wire logic I_CLK_SYS,   // system clock
  input wire logic I_RST_N,     // async reset, active low
  input wire logic I_CS_N,      // device select
  input wire logic O_DOUT,      // serial result
  input wire logic O_DOUT_OE_N, // output enable, low drives
  input wire logic O_EOC,       // conversion done
  input wire logic O_SAMPLE,    // sampling switch closed
  input wire logic O_PWRDN,     // power-down state
  input wire logic PSEL,        // apb select
  input wire logic PENABLE,     // apb enable
  input wire logic PREADY,      // apb ready
  input wire logic PSLVERR      // apb error
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  // first edge after reset must still show the idle, powered-down state
  property p_rst_idle; $rose(I_RST_N) |-> O_EOC && O_PWRDN; endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("idle state missing after reset");
  // the line carries zeros for the whole conversion
  property p_conv_zero; !O_EOC |-> !O_DOUT; endproperty
  a_conv_zero: assert property (p_conv_zero)
    else $error("serial output not zero while converting");
  property p_samp_eoc; O_SAMPLE |-> O_EOC; endproperty
  a_samp_eoc: assert property (p_samp_eoc)
    else $error("done flag low during sampling");
  // a little slack: the flag may trail the switch by a few clocks
  property p_samp_end; $fell(O_SAMPLE) |-> ##[0:4] !O_EOC; endproperty
  a_samp_end: assert property (p_samp_end)
    else $error("conversion did not follow end of sampling");
  property p_samp_pd; O_SAMPLE |-> !O_PWRDN; endproperty
  a_samp_pd: assert property (p_samp_pd)
    else $error("sampling while powered down");
  property p_pd_idle; O_PWRDN |-> O_EOC; endproperty
  a_pd_idle: assert property (p_pd_idle)
    else $error("conversion while powered down");
  property p_desel; $rose(I_CS_N) |-> ##[1:4] O_DOUT_OE_N; endproperty
  a_desel: assert property (p_desel)
    else $error("output not released on deselect");
  property p_sel; $fell(I_CS_N) |-> ##[1:4] !O_DOUT_OE_N; endproperty
  a_sel: assert property (p_sel)
    else $error("output not driven after select");
  property p_rdy; PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY; endproperty
  a_rdy: assert property (p_rdy)
    else $error("bus answer not after one wait state");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err)
    else $error("bus error without ready");
endmodule : sadc_ctrl_chk

bind sadc_ctrl sadc_ctrl_chk sadc_ctrl_chk_i (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N),
  .O_DOUT(O_DOUT), .O_DOUT_OE_N(O_DOUT_OE_N), .O_EOC(O_EOC),
  .O_SAMPLE(O_SAMPLE), .O_PWRDN(O_PWRDN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR));

// file: tb/sadc_host.sv
`timescale 1ns/1ps
// ==========================================================
// host serial port: shift clock stands low outside frames
module sadc_host (
  input  wire logic I_CLK_SYS, // system clock
  input  wire logic dout,      // data line, z when released
  output logic      io_clk,    // shift clock, 200 ns period
  output logic      cs_n,      // device select
  output logic      din        // command line
);
  initial
  begin
    io_clk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge I_CLK_SYS);
  endtask : tk

  // settle time covers sync, debounce and the quiet clock after select
  task automatic sel(input logic v);
    @(posedge I_CLK_SYS);
    cs_n <= v;
    tk(14);
  endtask : sel

  // one frame; result bits are taken just before each falling edge
  task automatic xfer(input logic [7:0] cmd, input int n,
                      output logic [15:0] rx);
    rx = '0;
    for (int i = 0; i < n; i++)
    begin
      din <= (i < 8) ? cmd[7-i] : ~din; // idle line keeps toggling
      tk(4);
      io_clk <= 1'b1;
      tk(3);
      rx = {rx[14:0], dout};
      @(posedge I_CLK_SYS);
      io_clk <= 1'b0;
    end
    din <= ~din;
    tk(6);
  endtask : xfer
endmodule : sadc_host

// file: tb/tb.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench
module tb;
  import sadc_pkg::*;
  logic        clk, rst_n, psel, pen, pwr, lsb_first_bit, e;
  logic [1:0]  plen;
  logic [7:0]  paddr, cmd;
  logic [31:0] pwdata, q;
  result_t     raw, last;
  wire logic   io_clk, cs_n, din, dout, oe_n, eoc, samp, pd, rdy, err;
  wire logic [3:0]  chan;
  wire logic [31:0] prdata;
  wire logic   dline = oe_n ? 1'bz : dout;
  int          fail_count = 0;
  int          checks_done = 0;
  // hand-written corners: test voltages, lsb first, power-down, abort
  logic [7:0]  corner_cmds [6] = '{8'hB4, 8'hCD, 8'h7F, 8'hEC, 8'h58,
                                   8'h30};

  sadc_ctrl sadc_ctrl_i (.I_CLK_SYS(clk), .I_RST_N(rst_n),
    .I_IO_CLK(io_clk), .I_CS_N(cs_n), .I_DIN(din), .I_CONV_RAW(raw),
    .O_DOUT(dout), .O_DOUT_OE_N(oe_n), .O_EOC(eoc), .O_SAMPLE(samp),
    .O_CHAN(chan), .O_PWRDN(pd), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(rdy), .PSLVERR(err));
  sadc_host sadc_host_i (.I_CLK_SYS(clk), .dout(dline), .io_clk(io_clk),
    .cs_n(cs_n), .din(din));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 20);
    if (rdy !== 1'b1)
      fail_count++;
    q = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  function automatic int blen(logic [1:0] l);
    return (l == 2'b01) ? 8 : (l == 2'b11) ? 16 : 12;
  endfunction : blen

  function automatic result_t code(logic [3:0] a, result_t x, logic s);
    result_t v;
    v = (a == 4'hB) ? 12'h800 : (a == 4'hC) ? 12'h000 :
        (a == 4'hD) ? 12'hFFF : x;
    return s ? (v ^ 12'h800) : v;
  endfunction : code

  // expected bits as shifted in, first bit highest
  function automatic logic [15:0] bits(result_t c, logic l, int n);
    logic [15:0] m, r;
    m = {c, 4'h0};
    r = m >> (16 - n);
    if (l)
      for (int j = 0; j < n; j++) r[j] = m[15-j];
    return r;
  endfunction : bits

  // a frame sends the previous result; abort drops the new conversion
  task automatic frame(input logic [7:0] c, input logic ck, input logic ab);
    logic [15:0] rx;
    int n;
    n = blen(c[3:2]);
    raw <= 12'($urandom);
    sadc_host_i.xfer(c, n, rx);
    if (ck) chk(rx, bits(last, lsb_first_bit, n));
    if (c[7:4] != 4'hE) chk(16'(chan), 16'(c[7:4]));
    chk(16'(pd), 16'(c[7:4] == 4'hE));
    if (ab)
    begin
      sadc_host_i.sel(1'b1);
      chk(16'(dline), {15'h0, 1'bz});
      sadc_host_i.sel(1'b0);
    end
    else if (c[7:4] != 4'hE) last = code(c[7:4], raw, c[0]);
    lsb_first_bit = c[1];
    plen = c[3:2];
    for (int k = 0; k < 200 && eoc !== 1'b1; k++) @(posedge clk);
    chk(16'(eoc), 16'h0001);
    $display("frame %h done", c);
  endtask : frame

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  initial
  begin
    {rst_n, psel, pen, pwr, lsb_first_bit} = '0;
    {paddr, pwdata, raw, last, plen} = '0;
    void'($urandom(88));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(16'({pd, eoc}), 16'h0003);
    apb(1'b0, 8'h04, 32'h0);
    chk(q[15:0], 16'h0004);
    apb(1'b1, 8'h00, 32'h0000_0028);
    apb(1'b0, 8'h00, 32'h0);
    chk(q[15:0], 16'h0028);
    apb(1'b0, 8'h10, 32'h0);
    chk({e, q[14:0]}, 16'h8000);
    $display("register test done");
    sadc_host_i.sel(1'b0);
    frame(8'hD0, 1'b0, 1'b0);
    foreach (corner_cmds[i])
      frame(corner_cmds[i], 1'b1, i == 5);
    frame(8'h90, 1'b1, 1'b0);
    for (int i = 0; i < 10; i++)
    begin
      cmd = 8'($urandom);
      cmd[7:4] = 4'($urandom_range(0, 13));
      if (lsb_first_bit) cmd[3:2] = plen; // length change would corrupt this frame
      frame(cmd, 1'b1, 1'b0);
    end
    close_out();
  end

  // watchdog, well beyond the expected run of about 65 us
  initial
  begin
    #1_000_000;
    fail_count++;
    close_out();
  end
endmodule : tb
